// file: verilog/abx_exec.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// and / bit-clear / relative-branch execution slice
// ==========================================================
// Summary of operation
// - file and with accumulator, msb/clear flags
// - dest 0 accumulator, dest 1 file
// - access bit picks access bank or bank
// - extended set indexes low access addresses
// - taken target is pc plus 2 plus 2n
// - branch one cycle, taken adds nop cycle
// - carry set branch, flags untouched
// - carry clear branch, flags untouched
// - msb set branch, flags untouched
// - clear one file bit in one cycle
module abx_exec
  import abx_pkg::*;
#(
  parameter int PCW = 21,
  parameter int BANKS = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);

  abx_phase_e phase;
  abx_op_e op;
  logic nop_cyc;
  logic [15:0] instr;
  logic [7:0] accum;
  logic carry;
  logic all_clear_flag;
  logic msb_flag;
  logic illegal;
  logic ext_en;
  logic [3:0] bank_select_pointer;
  logic [PCW-1:0] pc;
  logic [11:0] index_base;
  logic [11:0] file_addr;
  logic [31:0] cycles;
  logic [7:0] rd_data;
  logic [7:0] result;
  logic taken;
  logic ack;
  logic wr_hs;
  logic mapped;
  logic issue;
  logic core_wr;
  logic sw_file_wr;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [31:0] next_rdata;
  logic [PCW-1:0] next_pc;
  logic [PCW-1:0] pc_step;

  // ========================================================
  // apb slave
  // ========================================================
  // answer in the second access cycle; stalls while executing
  assign pready = ack;
  assign wr_hs = psel && penable && ack && pwrite;
  assign issue = wr_hs && paddr == OFF_INSTR;
  assign sw_file_wr = wr_hs && paddr == OFF_FILE_DATA;
  assign busy = phase != ABX_IDLE;

  // read mux; unmapped offsets read zero and raise an error
  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: next_rdata[CTRL_EXT_POS] = ext_en;
      OFF_INSTR: next_rdata[15:0] = instr;
      OFF_ACCUM: next_rdata[7:0] = accum;
      OFF_STATUS: begin
        next_rdata[ST_CARRY_POS] = carry;
        next_rdata[ST_CLEAR_POS] = all_clear_flag;
        next_rdata[ST_MSB_POS] = msb_flag;
        next_rdata[ST_ILLEGAL_POS] = illegal;
        next_rdata[ST_BUSY_POS] = busy;
      end
      OFF_BANK: next_rdata[3:0] = bank_select_pointer;
      OFF_PC: next_rdata[PCW-1:0] = pc;
      OFF_INDEX: next_rdata[11:0] = index_base;
      OFF_FILE_ADDR: next_rdata[11:0] = file_addr;
      OFF_FILE_DATA: next_rdata[7:0] = rd_data;
      OFF_CYCLES: next_rdata = cycles;
      default: mapped = 1'b0;
    endcase
  end

  // handshake: first access cycle loads data, second answers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !ack && !busy) begin
      // one answer per access, never while executing
      ack <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= !mapped;
    end else begin
      // ready drops after one cycle; prdata stands
      ack <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ========================================================
  // software-owned configuration
  // ========================================================
  // writes only land while idle, so no race with execution
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_en <= 1'b0;
      bank_select_pointer <= BANK_RESET;
      index_base <= INDEX_RESET;
      file_addr <= FILE_ADDR_RESET;
      instr <= INSTR_RESET;
    end else if (wr_hs) begin
      case (paddr)
        OFF_CTRL: ext_en <= pwdata[CTRL_EXT_POS];
        OFF_BANK: bank_select_pointer <= pwdata[3:0];
        OFF_INDEX: index_base <= pwdata[11:0];
        OFF_FILE_ADDR: file_addr <= pwdata[11:0];
        OFF_INSTR: instr <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ========================================================
  // four-phase sequencer
  // ========================================================
  // a taken branch replays q1..q4 as a forced no-operation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= ABX_IDLE;
      nop_cyc <= 1'b0;
    end else begin
      case (phase)
        ABX_IDLE: begin
          nop_cyc <= 1'b0;
          if (issue) begin
            phase <= ABX_Q1;
          end
        end
        // q1 decode, q2 read, q3 process, q4 write
        ABX_Q1: phase <= ABX_Q2;
        ABX_Q2: phase <= ABX_Q3;
        ABX_Q3: phase <= ABX_Q4;
        ABX_Q4: begin
          if (!nop_cyc && op == ABX_OP_BRANCH && taken) begin
            phase <= ABX_Q1;
            nop_cyc <= 1'b1;
          end else begin
            phase <= ABX_IDLE;
            nop_cyc <= 1'b0;
          end
        end
        default: phase <= ABX_IDLE;
      endcase
    end
  end

  // instruction cycles completed, a taken branch counts two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycles <= 32'h0000_0000;
    end else if (phase == ABX_Q4) begin
      cycles <= cycles + 32'h0000_0001;
    end
  end

  // ========================================================
  // decode in q1
  // ========================================================
  // the replayed nop cycle keeps the decoded class
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op <= ABX_OP_BAD;
    end else if (phase == ABX_Q1 && !nop_cyc) begin
      if (instr[15:8] == OPC_AND_LIT) begin
        op <= ABX_OP_AND_LIT;
      end else if (instr[15:10] == OPC_AND_FILE) begin
        op <= ABX_OP_AND_FILE;
      end else if (instr[15:12] == OPC_BIT_CLEAR) begin
        op <= ABX_OP_BIT_CLEAR;
      end else if (instr[15:12] == OPC_BRANCH &&
                   (instr[11:8] == BR_CARRY_SET ||
                    instr[11:8] == BR_CARRY_CLEAR ||
                    instr[11:8] == BR_MSB_SET)) begin
        op <= ABX_OP_BRANCH;
      end else begin
        op <= ABX_OP_BAD;
      end
    end
  end

  // ========================================================
  // process in q3
  // ========================================================
  // branch condition per opcode; flags are only looked at
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      taken <= 1'b0;
    end else if (phase == ABX_Q3 && !nop_cyc) begin
      // decided for every word, used only for a branch
      case (instr[11:8])
        BR_CARRY_SET: taken <= carry;
        BR_CARRY_CLEAR: taken <= !carry;
        BR_MSB_SET: taken <= msb_flag;
        default: taken <= 1'b0;
      endcase
    end
  end

  // file data is valid in q3, one cycle after the q2 read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result <= 8'h00;
    end else if (phase == ABX_Q3 && !nop_cyc) begin
      case (op)
        ABX_OP_AND_LIT: result <= accum & instr[7:0];
        ABX_OP_AND_FILE: result <= accum & rd_data;
        ABX_OP_BIT_CLEAR:
          result <= rd_data & ~(8'h01 << instr[11:9]);
        default: result <= 8'h00;
      endcase
    end
  end

  // ========================================================
  // write back in q4
  // ========================================================
  // bit clear always writes back, the and only for dest 1
  assign core_wr = phase == ABX_Q4 && !nop_cyc &&
    ((op == ABX_OP_AND_FILE && instr[DEST_POS]) ||
     op == ABX_OP_BIT_CLEAR);
  assign mem_wr = core_wr || sw_file_wr;
  assign mem_wdata = core_wr ? result : pwdata[7:0];

  // accumulator: literal and, or file and with dest 0
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accum <= ACCUM_RESET;
    end else if (phase == ABX_Q4 && !nop_cyc &&
                 (op == ABX_OP_AND_LIT ||
                  (op == ABX_OP_AND_FILE && !instr[DEST_POS]))) begin
      accum <= result;
    end else if (wr_hs && paddr == OFF_ACCUM) begin
      // software load only lands while idle
      accum <= pwdata[7:0];
    end
  end

  // status: only the and forms touch msb and all-clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carry <= 1'b0;
      all_clear_flag <= 1'b0;
      msb_flag <= 1'b0;
      illegal <= 1'b0;
    end else if (phase == ABX_Q4 && !nop_cyc) begin
      if (op == ABX_OP_AND_LIT || op == ABX_OP_AND_FILE) begin
        all_clear_flag <= result == 8'h00;
        msb_flag <= result[7];
      end
      // unknown opcodes leave only a sticky marker
      if (op == ABX_OP_BAD) begin
        illegal <= 1'b1;
      end
    end else if (wr_hs && paddr == OFF_STATUS) begin
      carry <= pwdata[ST_CARRY_POS];
      all_clear_flag <= pwdata[ST_CLEAR_POS];
      msb_flag <= pwdata[ST_MSB_POS];
      // write one to clear; hardware sets only while busy
      illegal <= illegal && !pwdata[ST_ILLEGAL_POS];
    end
  end

  // ========================================================
  // program counter
  // ========================================================
  // one instruction word is two bytes
  assign pc_step = PCW'(2);

  // target is formed every cycle but only loaded in q4
  always_comb begin
    if (op == ABX_OP_BRANCH && taken) begin
      // sign-extended offset doubled, from the next word
      next_pc = pc + pc_step +
        {{(PCW-9){instr[7]}}, instr[7:0], 1'b0};
    end else begin
      next_pc = pc + pc_step;
    end
  end

  // software moves the pc only while the core is idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= '0;
    end else if (phase == ABX_Q4 && !nop_cyc) begin
      pc <= next_pc;
    end else if (wr_hs && paddr == OFF_PC) begin
      pc <= {pwdata[PCW-1:1], 1'b0};
    end
  end

  // ========================================================
  // file register memory
  // ========================================================
  // core owns the memory address while busy, software otherwise
  abx_file_mem #(
    .BANKS(BANKS)
  ) u_mem (
    .clk(clk),
    .core_sel(busy),
    .f_addr(instr[7:0]),
    .access_bit(instr[ACCESS_POS]),
    .bank_select_pointer(bank_select_pointer),
    .ext_en(ext_en),
    .index_base(index_base),
    .sw_addr(file_addr),
    .wr_en(mem_wr),
    .wr_data(mem_wdata),
    .rd_data(rd_data)
  );

endmodule // abx_exec
`default_nettype wire

// file: verilog/abx_pkg.sv
// ==========================================================
// shared constants of the and / bit-clear / branch slice
// ==========================================================
`default_nettype none
package abx_pkg;

  // ========================================================
  // apb register byte offsets
  // ========================================================
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_ACCUM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_BANK = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_INDEX = 8'h18;
  localparam logic [7:0] OFF_FILE_ADDR = 8'h1c;
  localparam logic [7:0] OFF_FILE_DATA = 8'h20;
  localparam logic [7:0] OFF_CYCLES = 8'h24;

  // ========================================================
  // register field positions
  // ========================================================
  localparam int CTRL_EXT_POS = 0;
  localparam int ST_CARRY_POS = 0;
  localparam int ST_CLEAR_POS = 1;
  localparam int ST_MSB_POS = 2;
  localparam int ST_ILLEGAL_POS = 3;
  localparam int ST_BUSY_POS = 4;

  // ========================================================
  // instruction word fields and opcodes
  // ========================================================
  localparam int DEST_POS = 9;
  localparam int ACCESS_POS = 8;
  localparam logic [7:0] OPC_AND_LIT = 8'h0b;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [3:0] OPC_BRANCH = 4'he;
  localparam logic [3:0] BR_CARRY_SET = 4'h2;
  localparam logic [3:0] BR_CARRY_CLEAR = 4'h3;
  localparam logic [3:0] BR_MSB_SET = 4'h6;

  // ========================================================
  // addressing and reset values
  // ========================================================
  localparam logic [7:0] ACCESS_SPLIT = 8'h5f;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] INDEX_RESET = 12'h000;
  localparam logic [11:0] FILE_ADDR_RESET = 12'h000;

  // ========================================================
  // types
  // ========================================================
  typedef enum logic [2:0] {
    ABX_IDLE, ABX_Q1, ABX_Q2, ABX_Q3, ABX_Q4
  } abx_phase_e;

  typedef enum logic [2:0] {
    ABX_OP_AND_LIT, ABX_OP_AND_FILE, ABX_OP_BIT_CLEAR,
    ABX_OP_BRANCH, ABX_OP_BAD
  } abx_op_e;

endpackage
`default_nettype wire

// file: verilog/abx_file_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// file register memory with address resolution
// ==========================================================
module abx_file_mem
  import abx_pkg::*;
#(
  parameter int BANKS = 16
) (
  input wire logic clk,
  input wire logic core_sel,
  input wire logic [7:0] f_addr,
  input wire logic access_bit,
  input wire logic [3:0] bank_select_pointer,
  input wire logic ext_en,
  input wire logic [11:0] index_base,
  input wire logic [11:0] sw_addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);

  logic [7:0] mem [BANKS*256];
  logic [11:0] core_addr;
  logic [11:0] addr;
  logic [11:0] top_bank;

  assign top_bank = 12'(BANKS - 1);

  // ========================================================
  // resolve the 8-bit file field to a physical address
  // ========================================================
  always_comb begin
    if (access_bit) begin
      core_addr = {bank_select_pointer, f_addr};
    end else if (ext_en && f_addr <= ACCESS_SPLIT) begin
      // indexed literal offset: base plus literal field
      core_addr = index_base + {4'h0, f_addr};
    end else if (f_addr <= ACCESS_SPLIT) begin
      core_addr = {4'h0, f_addr};
    end else begin
      // upper access half sits in the last bank
      core_addr = {top_bank[3:0], f_addr};
    end
  end

  assign addr = core_sel ? core_addr : sw_addr;

  // one-cycle registered read; write and read share the address
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule // abx_file_mem
`default_nettype wire

// file: testbench/abx_exec_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for the execution slice
// ==========================================================
module abx_exec_sva
  import abx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  logic [15:0] instr_q;
  logic bad_addr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // last issued instruction, so lengths can be tied to the opcode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_q <= 16'h0000;
    end else if (psel && penable && pready && pwrite &&
                 paddr == OFF_INSTR) begin
      instr_q <= pwdata[15:0];
    end
  end

  // anything past the last register or off word alignment
  assign bad_addr = (paddr > OFF_CYCLES) || (paddr[1:0] != 2'h0);

  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_decode: assert property (pready |-> pslverr == bad_addr)
    else $error("error response does not match address");
  a_err_alone: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_idle_answer: assert property ($rose(penable) && psel && !busy
    |-> !pready ##1 pready)
    else $error("idle transfer not answered in second access");
  a_write_rdata: assert property (pready && pwrite |-> prdata == 0)
    else $error("read data not zero on write");
  a_busy_stall: assert property (busy |-> !pready)
    else $error("transfer answered while busy");
  a_instr_launch: assert property (pready && pwrite &&
    paddr == OFF_INSTR && !pslverr |=> busy)
    else $error("instruction write did not start execution");
  a_single_cycle: assert property ($rose(busy) &&
    instr_q[15:12] != OPC_BRANCH |-> busy [*4] ##1 !busy)
    else $error("single cycle op wrong length");
  a_branch_len: assert property ($rose(busy) &&
    instr_q[15:12] == OPC_BRANCH
    |-> (busy [*4] ##1 !busy) or (busy [*8] ##1 !busy))
    else $error("branch length not one or two cycles");

  c_taken: cover property ($rose(busy) ##0 busy [*8]);
  c_err: cover property (pready && pslverr);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_stall: cover property (psel && penable && busy);
endmodule // abx_exec_sva

bind abx_exec abx_exec_sva u_sva (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy)
);
`default_nettype wire

// file: testbench/abx_exec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-checking bench over the apb port
// ==========================================================
module abx_exec_tb_top
  import abx_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, c0, pc_x;
  logic re;
  int failures, samples_checked, i;
  logic [3:0] cnd [6] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h6, 4'h6};
  logic [7:0] stv [6] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h04, 8'h03};
  logic [7:0] off [6] = '{8'h05, 8'h05, 8'h80, 8'h80, 8'h7f, 8'h7f};
  logic tk [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  abx_exec #(.PCW(21), .BANKS(16)) dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy)
  );

  // 4 ns period
  always #2 clk = ~clk;

  // ========================================================
  // tasks
  // ========================================================
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // idle edge first so a release never meets a new request
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      test_done();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rv, x);
  endtask

  // issue one instruction and count the busy clocks
  task automatic exe(input logic [15:0] ins, input int nb);
    int k, n;
    wr(OFF_INSTR, {16'h0000, ins});
    n = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (busy !== 1'b1) break;
      n++;
    end
    if (k == 40) begin
      failures++;
      test_done();
    end
    chk(n, nb);
  endtask

  // ========================================================
  // main sequence
  // ========================================================
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(OFF_ACCUM, 32'h0);
    rd(OFF_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(1'b1, 8'h26, 32'hff);
    chk({31'h0, re}, 32'h1);
    $display("test reset done");
    // literal and, then an all-zero result
    wr(OFF_ACCUM, 32'ha3);
    exe(16'h0b5f, 4);
    rd(OFF_ACCUM, 32'h03);
    rd(OFF_STATUS, 32'h00);
    exe(16'h0b00, 4);
    rd(OFF_STATUS, 32'h02);
    rd(OFF_PC, 32'h4);
    // unknown opcode: sticky marker, cleared only by a one
    exe(16'hffff, 4);
    rd(OFF_STATUS, 32'h0a);
    wr(OFF_STATUS, 32'h02);
    rd(OFF_STATUS, 32'h0a);
    wr(OFF_STATUS, 32'h08);
    rd(OFF_STATUS, 32'h00);
    rd(OFF_PC, 32'h6);
    $display("test literal done");
    // file and to accumulator, then back into the file
    wr(OFF_FILE_ADDR, 32'h020);
    wr(OFF_FILE_DATA, 32'hc2);
    wr(OFF_ACCUM, 32'h17);
    exe(16'h1420, 4);
    rd(OFF_ACCUM, 32'h02);
    rd(OFF_FILE_DATA, 32'hc2);
    wr(OFF_ACCUM, 32'h80);
    exe(16'h1620, 4);
    rd(OFF_FILE_DATA, 32'h80);
    rd(OFF_STATUS, 32'h04);
    $display("test file and done");
    // banked access must leave the access-bank copy alone
    wr(OFF_BANK, 32'h3);
    wr(OFF_FILE_ADDR, 32'h320);
    wr(OFF_FILE_DATA, 32'h0f);
    wr(OFF_ACCUM, 32'h3c);
    exe(16'h1720, 4);
    rd(OFF_FILE_DATA, 32'h0c);
    wr(OFF_FILE_ADDR, 32'h020);
    rd(OFF_FILE_DATA, 32'h80);
    $display("test bank done");
    // indexed low half, plain upper half, one bit cleared each
    wr(OFF_CTRL, 32'h1);
    wr(OFF_INDEX, 32'h100);
    wr(OFF_FILE_ADDR, 32'h110);
    wr(OFF_FILE_DATA, 32'hc7);
    wr(OFF_STATUS, 32'h05);
    exe(16'h9e10, 4);
    rd(OFF_FILE_DATA, 32'h47);
    rd(OFF_STATUS, 32'h05);
    wr(OFF_FILE_ADDR, 32'hf60);
    wr(OFF_FILE_DATA, 32'hff);
    exe(16'h9060, 4);
    rd(OFF_FILE_DATA, 32'hfe);
    $display("test bit clear done");
    // each branch taken and not taken, with edge offsets
    for (i = 0; i < 6; i++) begin
      wr(OFF_PC, 32'h400);
      wr(OFF_STATUS, {24'h0, stv[i]});
      apb(1'b0, OFF_CYCLES, 32'h0);
      c0 = rv;
      exe({OPC_BRANCH, cnd[i], off[i]}, tk[i] ? 8 : 4);
      pc_x = 32'h402 + (tk[i] ? {{23{off[i][7]}}, off[i], 1'b0} : 0);
      rd(OFF_PC, pc_x);
      rd(OFF_STATUS, {24'h0, stv[i]});
      rd(OFF_CYCLES, c0 + (tk[i] ? 2 : 1));
    end
    // a read while busy stalls until the taken branch ends
    apb(1'b0, OFF_CYCLES, 32'h0);
    c0 = rv;
    wr(OFF_STATUS, 32'h01);
    wr(OFF_INSTR, {16'h0000, OPC_BRANCH, BR_CARRY_SET, 8'h05});
    rd(OFF_CYCLES, c0 + 32'h2);
    rd(OFF_PC, 32'h40e);
    $display("test branch done");
    test_done();
  end
endmodule // abx_exec_tb_top
`default_nettype wire
